//--- design/etom_defs.svh
// Register offsets, field positions, reset values and timing counts of the output mapper.
// Included by the design modules etom_delay and etom_top; definitions only.
`ifndef ETOM_DEFS_SVH
`define ETOM_DEFS_SVH

`define ETOM_CLK_HZ        125000000
`define ETOM_TICK_CYCLES   (`ETOM_CLK_HZ / 1000)
`define ETOM_TICKS_PER_SEC 1000

// Register byte offsets
`define ETOM_OFF_CH_CFG0   12'h000
`define ETOM_OFF_APPLY     12'h040
`define ETOM_OFF_STATUS    12'h044
`define ETOM_OFF_IRQ_STAT  12'h048
`define ETOM_OFF_IRQ_MASK  12'h04C
`define ETOM_OFF_PSU_CMD   12'h050
`define ETOM_OFF_SETPOINT  12'h054
`define ETOM_OFF_CMD_STAT  12'h058

// Channel config fields
`define ETOM_F_SRC_LSB     0
`define ETOM_F_TRG_LSB     4
`define ETOM_F_ACT_BIT     8
`define ETOM_F_DLY_LSB     12

// Supply command fields
`define ETOM_F_CMD_ADDR    0
`define ETOM_F_CMD_ON      8
`define ETOM_F_CMD_ALL     9

`define ETOM_CFG_RESET     32'h0000_0000
`define ETOM_MAX_ADDR      47

`endif

//--- design/etom_pkg.sv
// Types shared by the output mapper modules.
// Assumes etom_defs.svh sits beside it.
package etom_pkg;
  typedef enum logic [2:0] {
    ETOM_SRC_ALARM, ETOM_SRC_PSU,
    ETOM_SRC_IN1, ETOM_SRC_IN2, ETOM_SRC_IN3, ETOM_SRC_IN4, ETOM_SRC_IN5
  } etom_src_t;
  typedef enum logic [2:0] {
    ETOM_TRG_ANY, ETOM_TRG_OVER_VOLT, ETOM_TRG_OVL_F, ETOM_TRG_SHORT,
    ETOM_TRG_OTP, ETOM_TRG_MAINS, ETOM_TRG_FAN
  } etom_trg_t;
  typedef enum logic [1:0] {ETOM_BUS_IDLE, ETOM_BUS_RESP} etom_bus_t;
endpackage

//--- design/etom_delay.sv
// One output channel: condition qualified by a programmable delay.
// Assumes a one-cycle millisecond tick from the parent.
`timescale 1ns/10ps
`include "etom_defs.svh"
module etom_delay
  import etom_pkg::*;
(
  // Clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       ms_tick,
  // Condition and delay choice
  input  wire logic       cond,
  input  wire logic [3:0] dly_sel,
  // Qualified state
  output logic            fired
);
  logic [19:0] target_ms;
  logic [19:0] count;

  always_comb begin
    case (dly_sel)
      4'h0:    target_ms = 20'h00000;
      4'h1:    target_ms = 20'(1 * `ETOM_TICKS_PER_SEC);
      4'h2:    target_ms = 20'(5 * `ETOM_TICKS_PER_SEC);
      4'h3:    target_ms = 20'(10 * `ETOM_TICKS_PER_SEC);
      4'h4:    target_ms = 20'(30 * `ETOM_TICKS_PER_SEC);
      default: target_ms = 20'((32'(dly_sel) - 32'h4) * 60 * `ETOM_TICKS_PER_SEC);
    endcase
  end

  // Count restarts whenever the condition drops
  always_ff @(posedge aclk) begin
    if (!aresetn || !cond) begin
      count <= 20'h00000;
      fired <= 1'b0;
    end else if (count >= target_ms) begin
      fired <= 1'b1;
    end else if (ms_tick) begin
      count <= count + 20'h00001;
    end
  end
endmodule

//--- design/etom_top.sv
// Event-triggered output mapper: five outputs, four relays, supply commands.
// Assumes supply status vectors synchronous to aclk and an AXI4-Lite master.
//
// How it works
// - Inputs are plain levels; an open input reads high from the pad pull-up.
// - Five input channels, each selectable as source, firing on its level.
// - Output status shows asserted while its condition holds, else deasserted.
// - Four relays with source, trigger, delay; open when fired, closed otherwise.
// - Each output holds source, trigger, active level and delay.
// - Source is alarm (default), supply state, or one input channel.
// - Alarm source fires on any online supply with selected fault or any fault.
// - Supply source with on fires when any online supply runs.
// - Supply source with off fires when any online supply is off or faulted.
// - Supply source with off also fires when all supplies are disconnected.
// - Active level selects high or low driven pin when fired.
// - Assertion follows condition after the chosen delay: 0,1,5,10,30 s, 1-11 min.
// - Supplies 0..47 switchable individually or all online together.
// - Commands to an offline supply are rejected without effect.
// - Voltage and current setpoints go out only on an apply command.
// - Edited channel settings stay pending until apply commits them.
//
// Implementation choices: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/10ps
`include "etom_defs.svh"
module etom_top
  import etom_pkg::*;
#(
  parameter int N_OUT = 5,
  parameter int N_REL = 4,
  parameter int N_PSU = 48,
  parameter int TICK_CYCLES = `ETOM_TICK_CYCLES
)(
  // Clock and reset
  input  wire logic             aclk,
  input  wire logic             aresetn,
  // AXI4-Lite slave
  input  wire logic [11:0]      s_axi_awaddr,
  input  wire logic             s_axi_awvalid,
  output logic                  s_axi_awready,
  input  wire logic [31:0]      s_axi_wdata,
  input  wire logic [3:0]       s_axi_wstrb,
  input  wire logic             s_axi_wvalid,
  output logic                  s_axi_wready,
  output logic [1:0]            s_axi_bresp,
  output logic                  s_axi_bvalid,
  input  wire logic             s_axi_bready,
  input  wire logic [11:0]      s_axi_araddr,
  input  wire logic             s_axi_arvalid,
  output logic                  s_axi_arready,
  output logic [31:0]           s_axi_rdata,
  output logic [1:0]            s_axi_rresp,
  output logic                  s_axi_rvalid,
  input  wire logic             s_axi_rready,
  // Field inputs and supply status
  input  wire logic [4:0]       din,
  input  wire logic [N_PSU-1:0] psu_online,
  input  wire logic [N_PSU-1:0] psu_running,
  input  wire logic [N_PSU-1:0] psu_remote_off,
  input  wire logic [N_PSU-1:0] over_voltage_fault,
  input  wire logic [N_PSU-1:0] overload_fault,
  input  wire logic [N_PSU-1:0] short_fault,
  input  wire logic [N_PSU-1:0] over_temp_fault,
  input  wire logic [N_PSU-1:0] mains_loss_fault,
  input  wire logic [N_PSU-1:0] fan_stall_fault,
  // Supply command port
  output logic                  psu_cmd_valid,
  output logic [5:0]            psu_cmd_addr,
  output logic                  psu_cmd_all,
  output logic                  psu_cmd_on,
  output logic                  setpoint_valid,
  output logic [15:0]           setpoint_volt,
  output logic [15:0]           setpoint_curr,
  // Outputs, relays, interrupt
  output logic [N_OUT-1:0]      dout,
  output logic [N_REL-1:0]      relay_open,
  output logic                  irq
);
  localparam int NCH = N_OUT + N_REL;

  logic [31:0]     cfg_pend [NCH];
  logic [31:0]     cfg_live [NCH];
  logic [N_PSU-1:0] any_fault;
  logic [NCH-1:0]  cond;
  logic [NCH-1:0]  fired;
  logic [NCH-1:0]  fired_q;
  logic [31:0]     tick_cnt;
  logic            ms_tick;
  logic [31:0]     irq_stat;
  logic [31:0]     irq_mask;
  logic [31:0]     setpoint_pend;
  logic            cmd_reject;
  logic [31:0]     next_rdata;
  logic            aw_held, w_held;
  logic [11:0]     aw_addr;
  logic [31:0]     w_data;
  logic            wr_fire, rd_fire;
  logic            rd_stat;

  ////////////////////////////////////////////////////////////////////
  // Millisecond tick
  always_ff @(posedge aclk) begin
    if (!aresetn || tick_cnt == 32'(TICK_CYCLES - 1)) tick_cnt <= 32'h0;
    else tick_cnt <= tick_cnt + 32'h1;
  end
  assign ms_tick = (tick_cnt == 32'(TICK_CYCLES - 1));

  ////////////////////////////////////////////////////////////////////
  // Condition per channel
  assign any_fault = over_voltage_fault | overload_fault | short_fault | over_temp_fault
                   | mains_loss_fault | fan_stall_fault;

  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      etom_src_t src;
      logic [2:0] trg;
      logic       alarm_hit;
      logic [2:0] in_idx;
      assign src = etom_src_t'(cfg_live[g][`ETOM_F_SRC_LSB +: 3]);
      assign trg = cfg_live[g][`ETOM_F_TRG_LSB +: 3];
      assign in_idx = 3'(src) - 3'(ETOM_SRC_IN1);
      // Offline supplies cannot alarm, so stale fault bits of a pulled unit are ignored
      always_comb begin
        case (etom_trg_t'(trg))
          ETOM_TRG_OVER_VOLT: alarm_hit = |(over_voltage_fault & psu_online);
          ETOM_TRG_OVL_F: alarm_hit = |(overload_fault & psu_online);
          ETOM_TRG_SHORT: alarm_hit = |(short_fault & psu_online);
          ETOM_TRG_OTP:   alarm_hit = |(over_temp_fault & psu_online);
          ETOM_TRG_MAINS: alarm_hit = |(mains_loss_fault & psu_online);
          ETOM_TRG_FAN:   alarm_hit = |(fan_stall_fault & psu_online);
          default:        alarm_hit = |(any_fault & psu_online);
        endcase
      end
      // Trigger bit 0 picks on/high (0) or off/low (1) for supply and input sources
      always_comb begin
        case (src)
          ETOM_SRC_ALARM: cond[g] = alarm_hit;
          ETOM_SRC_PSU:
            if (!trg[0]) cond[g] = |(psu_running & psu_online);
            else cond[g] = |((psu_remote_off | any_fault) & psu_online)
                         || (psu_online == '0);
          ETOM_SRC_IN1, ETOM_SRC_IN2, ETOM_SRC_IN3, ETOM_SRC_IN4, ETOM_SRC_IN5:
            cond[g] = din[in_idx] ^ trg[0];
          default: cond[g] = alarm_hit;
        endcase
      end
      etom_delay u_dly (
        .aclk    (aclk),
        .aresetn (aresetn),
        .ms_tick (ms_tick),
        .cond    (cond[g]),
        .dly_sel (cfg_live[g][`ETOM_F_DLY_LSB +: 4]),
        .fired   (fired[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////
  // Pin drive
  always_ff @(posedge aclk) begin
    for (int i = 0; i < N_OUT; i++) begin
      if (!aresetn) dout[i] <= 1'b0;
      else dout[i] <= fired[i] ^ cfg_live[i][`ETOM_F_ACT_BIT];
    end
    if (!aresetn) relay_open <= '0;
    else relay_open <= fired[NCH-1:N_OUT];
    if (!aresetn) fired_q <= '0;
    else fired_q <= fired;
  end

  ////////////////////////////////////////////////////////////////////
  // AXI4-Lite write path: address and data taken in either order
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign wr_fire = aw_held && w_held;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 12'h000;
      w_data  <= 32'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
      end
      if (wr_fire) begin
        aw_held <= 1'b0;
        w_held  <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr <= `ETOM_OFF_CMD_STAT) ? 2'h0 : 2'h2;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Register writes; wstrb ignored beyond a check that it is nonzero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < NCH; i++) begin
        cfg_pend[i] <= `ETOM_CFG_RESET;
        cfg_live[i] <= `ETOM_CFG_RESET;
      end
      irq_mask <= 32'h0;
      setpoint_pend <= 32'h0;
    end else if (wr_fire && s_axi_wstrb != 4'h0) begin
      if (aw_addr < `ETOM_OFF_APPLY && aw_addr[5:2] < 4'(NCH)) begin
        cfg_pend[aw_addr[5:2]] <= w_data;
      end else if (aw_addr == `ETOM_OFF_APPLY && w_data[0]) begin
        for (int i = 0; i < NCH; i++) cfg_live[i] <= cfg_pend[i];
      end else if (aw_addr == `ETOM_OFF_IRQ_MASK) begin
        irq_mask <= w_data;
      end else if (aw_addr == `ETOM_OFF_SETPOINT) begin
        setpoint_pend <= w_data;
      end
    end
  end

  // Supply commands and setpoint apply
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      psu_cmd_valid <= 1'b0;
      psu_cmd_addr <= 6'h00;
      psu_cmd_all <= 1'b0;
      psu_cmd_on <= 1'b0;
      cmd_reject <= 1'b0;
      setpoint_valid <= 1'b0;
      setpoint_volt <= 16'h0000;
      setpoint_curr <= 16'h0000;
    end else begin
      psu_cmd_valid <= 1'b0;
      cmd_reject <= 1'b0;
      setpoint_valid <= 1'b0;
      if (wr_fire && aw_addr == `ETOM_OFF_PSU_CMD) begin
        // Fields move only with an accepted pulse; a refused command leaves them
        if (w_data[`ETOM_F_CMD_ALL] ||
            (w_data[`ETOM_F_CMD_ADDR +: 6] <= 6'(`ETOM_MAX_ADDR) &&
             psu_online[w_data[`ETOM_F_CMD_ADDR +: 6]])) begin
          psu_cmd_addr <= w_data[`ETOM_F_CMD_ADDR +: 6];
          psu_cmd_on <= w_data[`ETOM_F_CMD_ON];
          psu_cmd_all <= w_data[`ETOM_F_CMD_ALL];
          psu_cmd_valid <= 1'b1;
        end else begin
          cmd_reject <= 1'b1;
        end
      end
      if (wr_fire && aw_addr == `ETOM_OFF_APPLY && w_data[1]) begin
        setpoint_valid <= 1'b1;
        setpoint_volt <= setpoint_pend[15:0];
        setpoint_curr <= setpoint_pend[31:16];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Interrupt: rises on fired edges and rejects; read clears, set wins
  assign rd_stat = rd_fire && s_axi_araddr == `ETOM_OFF_IRQ_STAT;
  always_ff @(posedge aclk) begin
    if (!aresetn) irq_stat <= 32'h0;
    else irq_stat <= (rd_stat ? 32'h0 : irq_stat)
                   | {22'h0, cmd_reject, NCH'(fired & ~fired_q)};
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) irq <= 1'b0;
    else irq <= |(irq_stat & irq_mask);
  end

  ////////////////////////////////////////////////////////////////////
  // AXI4-Lite read path, one cycle after address
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_fire = s_axi_arvalid && s_axi_arready;

  always_comb begin
    next_rdata = 32'h0;
    if (s_axi_araddr < `ETOM_OFF_APPLY && s_axi_araddr[5:2] < 4'(NCH))
      next_rdata = cfg_pend[s_axi_araddr[5:2]];
    // Bit 9 stays zero so the input levels sit at [14:10]
    else if (s_axi_araddr == `ETOM_OFF_STATUS)
      next_rdata = {17'h0, din, 1'b0, fired[NCH-1:0]} & 32'h0000_7DFF;
    else if (s_axi_araddr == `ETOM_OFF_IRQ_STAT)
      next_rdata = irq_stat;
    else if (s_axi_araddr == `ETOM_OFF_IRQ_MASK)
      next_rdata = irq_mask;
    else if (s_axi_araddr == `ETOM_OFF_SETPOINT)
      next_rdata = setpoint_pend;
    else if (s_axi_araddr == `ETOM_OFF_CMD_STAT)
      next_rdata = {16'h0, 2'h0, psu_cmd_addr, 8'h0};
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= 2'h0;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= (s_axi_araddr <= `ETOM_OFF_CMD_STAT) ? 2'h0 : 2'h2;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule

//--- testbench/etom_props.sv
// Port checker for the output mapper: bus handshakes, command pulses.
// Assumes a bind onto etom_top and a single clock domain.
`timescale 1ns/10ps
module etom_props (
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Register bus
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // Supply side
  input wire logic        psu_cmd_valid,
  input wire logic [5:0]  psu_cmd_addr,
  input wire logic        psu_cmd_all,
  input wire logic        psu_cmd_on,
  input wire logic        setpoint_valid,
  input wire logic        irq
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////
  a_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp moved");
  a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata moved");
  a_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during response");
  a_read_refused: assert property (s_axi_arready == !s_axi_rvalid)
    else $error("read accept wrong");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  a_cmd_single: assert property (psu_cmd_valid |=> !psu_cmd_valid)
    else $error("command pulse long");
  a_setpoint_single: assert property (setpoint_valid |=> !setpoint_valid)
    else $error("setpoint pulse long");
  a_cmd_addr_legal: assert property (
    psu_cmd_valid && !psu_cmd_all |-> psu_cmd_addr <= 6'h2F) else $error("bad address");
  a_cmd_fields_hold: assert property (
    !psu_cmd_valid |-> $stable({psu_cmd_addr, psu_cmd_all, psu_cmd_on}))
    else $error("fields moved");
  c_cmd: cover property (psu_cmd_valid);
  c_setpoint: cover property (setpoint_valid);
  c_irq: cover property ($rose(irq));
endmodule

bind etom_top etom_props etom_props_i (
  .aclk, .aresetn, .s_axi_awready, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
  .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
  .s_axi_rdata, .psu_cmd_valid, .psu_cmd_addr, .psu_cmd_all, .psu_cmd_on,
  .setpoint_valid, .irq
);

//--- testbench/etom_psu_model.sv
// Rack supplies and field wiring behind the mapper.
// Assumes the bench sets online units, faults and field levels.
`timescale 1ns/10ps
module etom_psu_model (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // Bench controls
  input  wire logic [47:0] online,
  input  wire logic [47:0] fault_at,
  input  wire logic [2:0]  fault_kind,
  input  wire logic [4:0]  din_drv,
  input  wire logic [4:0]  din_en,
  // Commands from the mapper
  input  wire logic        psu_cmd_valid,
  input  wire logic [5:0]  psu_cmd_addr,
  input  wire logic        psu_cmd_all,
  input  wire logic        psu_cmd_on,
  // Levels to the mapper
  output logic [4:0]       din,
  output logic [47:0]      psu_running,
  output logic [47:0]      psu_remote_off,
  output logic [5:0][47:0] flt
);
  logic [47:0] on_q;
  // Undriven field inputs float up to the pull-up
  assign din = (din_drv & din_en) | ~din_en;
  assign psu_running = on_q & online;
  assign psu_remote_off = ~on_q & online;
  always_comb begin
    for (int k = 0; k < 6; k++) begin
      flt[k] = (32'(fault_kind) == k) ? (fault_at & online) : '0;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      on_q <= '1;
    end else if (psu_cmd_valid && psu_cmd_all) begin
      on_q <= psu_cmd_on ? (on_q | online) : (on_q & ~online);
    end else if (psu_cmd_valid && psu_cmd_addr < 6'h30) begin
      on_q[psu_cmd_addr] <= psu_cmd_on;
    end
  end
endmodule

//--- testbench/test_etom_top.sv
// Random and corner tests of the mapper against the supply model.
// Assumes etom_top, etom_psu_model and etom_props compiled before it.
`timescale 1ns/10ps
module test_etom_top;
  logic             aclk = '0, aresetn = '0, awv = '0, wv = '0, bry = '0, arv = '0, rry = '0;
  logic             awr, wrd, bv, arr, rv, irq, cmd_v, cmd_all, cmd_on, sp_v;
  logic [1:0]       bresp, rresp, lr;
  logic [11:0]      ba = '0;
  logic [31:0]      wd = '0, rdata;
  logic [47:0]      online = '1, fault_at = '0, running, roff;
  logic [5:0][47:0] flt;
  logic [2:0]       fkind = '0;
  logic [4:0]       ddrv = '0, den = '0, din, dout;
  logic [5:0]       cmd_a;
  logic [15:0]      sp_vo, sp_cu;
  logic [3:0]       relay;
  int               n_mismatch = 0, comparisons = 0, n_sp = 0, n_cmd = 0;
  always #4 aclk = ~aclk;
  always @(posedge aclk) begin
    n_sp <= n_sp + int'(sp_v === 1'h1);
    n_cmd <= n_cmd + int'(cmd_v === 1'h1);
  end
  ////////////////////////////////////////
  etom_top #(.TICK_CYCLES(4)) etom_top_i (
    .aclk, .aresetn, .s_axi_awaddr(ba), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wrd),
    .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ba),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rv), .s_axi_rready(rry), .din, .psu_online(online),
    .psu_running(running), .psu_remote_off(roff), .over_voltage_fault(flt[0]),
    .overload_fault(flt[1]), .short_fault(flt[2]), .over_temp_fault(flt[3]),
    .mains_loss_fault(flt[4]), .fan_stall_fault(flt[5]), .psu_cmd_valid(cmd_v),
    .psu_cmd_addr(cmd_a), .psu_cmd_all(cmd_all), .psu_cmd_on(cmd_on),
    .setpoint_valid(sp_v), .setpoint_volt(sp_vo), .setpoint_curr(sp_cu), .dout,
    .relay_open(relay), .irq
  );
  etom_psu_model etom_psu_model_i (
    .aclk, .aresetn, .online, .fault_at, .fault_kind(fkind), .din_drv(ddrv),
    .din_en(den), .psu_cmd_valid(cmd_v), .psu_cmd_addr(cmd_a), .psu_cmd_all(cmd_all),
    .psu_cmd_on(cmd_on), .din, .psu_running(running), .psu_remote_off(roff), .flt
  );
  ////////////////////////////////////////
  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic settle;
    repeat (4) @(posedge aclk);
  endtask
  // Ready sampled at negedge so the release edge never races the slave
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] v,
                     output logic [31:0] d);
    logic [4:0] p;
    logic [4:0] t;
    logic [4:0] k;
    @(posedge aclk);
    p = w ? {2'h3, 1'($urandom), 2'h0} : {4'h1, 1'($urandom)};
    k = w ? 5'h04 : 5'h01;
    {awv, wv, bry, arv, rry} <= p;
    ba <= a;
    wd <= v;
    while (k != '0) begin
      @(negedge aclk);
      t = p & {awr, wrd, bv, arr, rv};
      d = rdata;
      lr = w ? bresp : rresp;
      @(posedge aclk);
      k = k & ~t;
      // Response ready may come late, so the answer has to stand
      p = (p & ~t) | (k & {2'h0, bv, 1'h0, rv});
      {awv, wv, bry, arv, rry} <= p;
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    logic [31:0] x;
    bus(1'h1, a, v, x);
  endtask
  function automatic logic [31:0] cw(input int s, input int t, input int a, input int dl);
    return {16'h0, 4'(dl), 3'h0, 1'(a), 1'h0, 3'(t), 1'h0, 3'(s)};
  endfunction
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    logic [31:0] c [9];
    logic [31:0] d;
    logic [8:0]  ex;
    logic [4:0]  lv;
    logic [4:0]  en;
    ex = '0;
    void'($urandom(70));
    repeat (12) @(posedge aclk);
    aresetn <= 1'h1;
    bus(1'h0, 12'h000, '0, d);
    chk(d, 32'h0);
    bus(1'h0, 12'h05C, '0, d);
    chk({lr, d}, {2'h2, 32'h0});
    wr(12'h05C, 32'h0);
    chk(lr, 2'h2);
    $display("test defaults done");
    repeat (4) begin
      for (int i = 0; i < 9; i++) begin
        c[i] = cw(2 + $urandom % 5, $urandom % 2, (i < 5) ? $urandom % 2 : 0, 0);
        wr(12'(4 * i), c[i]);
      end
      settle;
      chk({relay, dout}, ex);
      lv = 5'($urandom);
      en = 5'($urandom);
      ddrv <= lv;
      den <= en;
      lv = lv | ~en;
      wr(12'h040, 32'h1);
      settle;
      for (int i = 0; i < 9; i++) ex[i] = lv[c[i][2:0] - 3'h2] ^ c[i][4] ^ c[i][8];
      chk({relay, dout}, ex);
      bus(1'h0, 12'h044, '0, d);
      chk(d[14:10], lv);
    end
    $display("test inputs done");
    for (int t = 0; t < 7; t++) begin
      wr(12'h000, cw(0, t, 0, 0));
      wr(12'h040, 32'h1);
      for (int f = 0; f < 6; f++) begin
        fault_at <= 48'h1 << ($urandom % 48);
        fkind <= 3'(f);
        settle;
        chk(dout[0], t == 0 || t == f + 1);
      end
    end
    fault_at <= '0;
    $display("test alarm done");
    wr(12'h000, cw(1, 0, 0, 0));
    wr(12'h004, cw(1, 1, 0, 0));
    wr(12'h040, 32'h1);
    settle;
    chk(dout[1:0], 2'h1);
    wr(12'h050, 32'h200);
    settle;
    chk(dout[1:0], 2'h2);
    online <= 48'h1;
    wr(12'h050, 32'h100);
    settle;
    chk(dout[1:0], 2'h1);
    fault_at <= 48'h1;
    settle;
    chk(dout[1:0], 2'h3);
    fault_at <= '0;
    bus(1'h0, 12'h048, '0, d);
    wr(12'h050, 32'h105);
    settle;
    chk(34'(n_cmd), 34'h2);
    chk(irq, 1'h0);
    wr(12'h04C, 32'h200);
    settle;
    chk(irq, 1'h1);
    bus(1'h0, 12'h048, '0, d);
    chk(d[9], 1'h1);
    settle;
    chk(irq, 1'h0);
    online <= '0;
    settle;
    chk(dout[1:0], 2'h2);
    $display("test supply done");
    den <= 5'h1F;
    ddrv <= 5'h0;
    wr(12'h014, cw(2, 0, 0, 1));
    wr(12'h040, 32'h1);
    ddrv <= 5'h1;
    repeat (2000) @(posedge aclk);
    ddrv <= 5'h0;
    repeat (10) @(posedge aclk);
    ddrv <= 5'h1;
    repeat (3900) @(posedge aclk);
    chk(relay[0], 1'h0);
    repeat (200) @(posedge aclk);
    chk(relay[0], 1'h1);
    $display("test delay done");
    d = $urandom;
    wr(12'h054, d);
    settle;
    chk(34'(n_sp), 34'h0);
    wr(12'h040, 32'h2);
    settle;
    chk(34'(n_sp), 34'h1);
    chk({sp_cu, sp_vo}, d);
    $display("test setpoint done");
    summarize;
  end
  initial begin
    repeat (40000) @(posedge aclk);
    n_mismatch++;
    $display("BAD %0t watchdog expired", $time);
    summarize;
  end
endmodule
